// ### logic/ctc_pkg.sv
// constants for the crt timing and cursor register block
package ctc_pkg;
  localparam int IDX_W = 5;
  localparam logic [4:0] IDX_HS_START = 5'h04;
  localparam logic [4:0] IDX_HS_END = 5'h05;
  localparam logic [4:0] IDX_VT_LOW = 5'h06;
  localparam logic [4:0] IDX_NINTH = 5'h07;
  localparam logic [4:0] IDX_ROW_PRESET = 5'h08;
  localparam logic [4:0] IDX_ROW_HEIGHT = 5'h09;
  localparam logic [4:0] IDX_CUR_TOP = 5'h0A;
  localparam logic [4:0] IDX_CUR_BOT = 5'h0B;
  localparam logic [4:0] IDX_BASE_HI = 5'h0C;
  localparam logic [4:0] IDX_BASE_LO = 5'h0D;
  localparam logic [4:0] IDX_CPOS_HI = 5'h0E;
  localparam logic [4:0] IDX_CPOS_LO = 5'h0F;
  localparam logic [4:0] IDX_VS_START = 5'h10;
  localparam logic [4:0] IDX_VS_END = 5'h11;
  localparam logic [4:0] IDX_VACT_END = 5'h12;
  // field positions
  localparam int ODD_START_BIT = 7;
  localparam int SKEW_LO = 5;
  localparam int IRQ_CLEAR_N_BIT = 4;
  localparam int IRQ_ENABLE_N_BIT = 5;
  localparam int TEST_BIT = 6;
  // ninth bits held in the overflow register
  localparam int NINTH_VT_BIT = 0;
  localparam int NINTH_VACT_BIT = 1;
  localparam int NINTH_VS_BIT = 2;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int SKEW_DEPTH = 3;
endpackage

// ### logic/ctc_timing.sv
// crt retrace timing, row scan, cursor and light pen registers
module ctc_timing
(
  input wire logic clk,
  input wire logic rst,
  input wire logic index_data_select_line,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  input wire logic [7:0] hchar_count,
  input wire logic [15:0] mem_addr_count,
  input wire logic light_pen_strobe,
  output logic hretrace,
  output logic vretrace,
  output logic vactive,
  output logic cursor_out,
  output logic [4:0] row_scan,
  output logic [8:0] line_count,
  output logic [15:0] frame_base,
  output logic frame_start,
  output logic odd_start,
  output logic vertical_irq_out,
  output logic vertical_irq_oe
);
  import ctc_pkg::*;
  // the index survives data accesses, so a run of data writes or reads
  // may follow a single index write

  logic [ctc_pkg::IDX_W-1:0] index;
  logic [7:0] hsync_start;
  logic [7:0] hsync_end_ctrl;
  logic [7:0] vert_total_low;
  logic [7:0] ninth_bits;
  logic [7:0] row_scan_preset;
  logic [7:0] row_height;
  logic [7:0] cursor_top;
  logic [7:0] cursor_bottom_skew;
  logic [7:0] frame_base_high;
  logic [7:0] frame_base_low;
  logic [7:0] cursor_pos_high;
  logic [7:0] cursor_pos_low;
  logic [7:0] vsync_start_low;
  logic [7:0] vsync_end_irq_ctrl;
  logic [7:0] vert_active_end_low;
  logic [7:0] pen_addr_high;
  logic [7:0] pen_addr_low;
  logic hs_raw;
  logic [SKEW_DEPTH-1:0] hs_delay;
  logic [SKEW_DEPTH-1:0] cur_delay;
  logic irq_pending;
  logic pen_last;
  logic reg_wr;
  logic data_wr;
  logic line_step;
  logic [8:0] vert_total;
  logic [8:0] vs_start;
  logic [8:0] vact_end;
  logic cur_raw;
  logic next_hretrace;
  logic next_cursor;

  // join an overflow bit with its low byte
  function automatic logic [8:0] ninth(input logic hi, input logic [7:0] lo);
    ninth = {hi, lo};
  endfunction

  // pick a tap of a skew line; code zero means no delay
  function automatic logic tap(input logic [1:0] code, input logic now,
                               input logic [SKEW_DEPTH-1:0] line);
    case (code)
      2'h0: tap = now;
      2'h1: tap = line[0];
      2'h2: tap = line[1];
      default: tap = line[2];
    endcase
  endfunction

  // the select line alone steers a write to the index or the data slot;
  // a read with the select line low leaves data_out untouched
  assign reg_wr = wr_strobe && !index_data_select_line;
  assign data_wr = wr_strobe && index_data_select_line;
  assign vert_total = ninth(ninth_bits[NINTH_VT_BIT], vert_total_low);
  assign vs_start = ninth(ninth_bits[NINTH_VS_BIT], vsync_start_low);
  assign vact_end = ninth(ninth_bits[NINTH_VACT_BIT], vert_active_end_low);
  // a scan line is counted at the start of horizontal retrace
  assign line_step = !hs_raw && (hchar_count == hsync_start);

  // index register, only the five low bits matter
  always_ff @(posedge clk)
  begin
    if (rst)
      index <= '0;
    else if (reg_wr)
      index <= data_in[IDX_W-1:0];
  end

  // data register writes through the index
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hsync_start <= REG_RESET;
      hsync_end_ctrl <= REG_RESET;
      vert_total_low <= REG_RESET;
      ninth_bits <= REG_RESET;
      row_scan_preset <= REG_RESET;
      row_height <= REG_RESET;
      cursor_top <= REG_RESET;
      cursor_bottom_skew <= REG_RESET;
      frame_base_high <= REG_RESET;
      frame_base_low <= REG_RESET;
      cursor_pos_high <= REG_RESET;
      cursor_pos_low <= REG_RESET;
      vsync_start_low <= REG_RESET;
      vsync_end_irq_ctrl <= REG_RESET;
      vert_active_end_low <= REG_RESET;
    end
    else if (data_wr)
    begin
      case (index)
        IDX_HS_START: hsync_start <= data_in;
        IDX_HS_END: hsync_end_ctrl <= data_in;
        IDX_VT_LOW: vert_total_low <= data_in;
        IDX_NINTH: ninth_bits <= data_in;
        IDX_ROW_PRESET: row_scan_preset <= data_in;
        IDX_ROW_HEIGHT: row_height <= data_in;
        IDX_CUR_TOP: cursor_top <= data_in;
        IDX_CUR_BOT: cursor_bottom_skew <= data_in;
        IDX_BASE_HI: frame_base_high <= data_in;
        IDX_BASE_LO: frame_base_low <= data_in;
        IDX_CPOS_HI: cursor_pos_high <= data_in;
        IDX_CPOS_LO: cursor_pos_low <= data_in;
        IDX_VS_START: vsync_start_low <= data_in;
        // test bit is stored only; software keeps it zero
        IDX_VS_END: vsync_end_irq_ctrl <= data_in;
        IDX_VACT_END: vert_active_end_low <= data_in;
        default: ;
      endcase
    end
  end

  // light pen bytes share the slots of two write-only timing registers
  // readback; the other write-only registers read as zero
  always_ff @(posedge clk)
  begin
    if (rst)
      data_out <= REG_RESET;
    else if (rd_strobe && index_data_select_line)
    begin
      case (index)
        IDX_BASE_HI: data_out <= frame_base_high;
        IDX_BASE_LO: data_out <= frame_base_low;
        IDX_CPOS_HI: data_out <= cursor_pos_high;
        IDX_CPOS_LO: data_out <= cursor_pos_low;
        IDX_VS_START: data_out <= pen_addr_high;
        IDX_VS_END: data_out <= pen_addr_low;
        default: data_out <= REG_RESET;
      endcase
    end
  end

  // a strobe held high latches once; it must drop before the next hit
  // light pen latch on the rising edge of the strobe
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pen_last <= 1'b0;
      pen_addr_high <= REG_RESET;
      pen_addr_low <= REG_RESET;
    end
    else
    begin
      pen_last <= light_pen_strobe;
      if (light_pen_strobe && !pen_last)
      begin
        pen_addr_high <= mem_addr_count[15:8];
        pen_addr_low <= mem_addr_count[7:0];
      end
    end
  end

  // undelayed horizontal retrace; end compare uses five bits only
  always_ff @(posedge clk)
  begin
    if (rst)
      hs_raw <= 1'b0;
    else if (hchar_count == hsync_start)
      hs_raw <= 1'b1;
    else if (hchar_count[4:0] == hsync_end_ctrl[4:0])
      hs_raw <= 1'b0;
  end

  // deeper skews cost one flip-flop each; three stages cover code three
  // delay line used by the retrace skew only, the cursor has its own; one stage per character
  always_ff @(posedge clk)
  begin
    if (rst)
      hs_delay <= '0;
    else
      hs_delay <= {hs_delay[SKEW_DEPTH-2:0], hs_raw};
  end

  assign next_hretrace = tap(hsync_end_ctrl[SKEW_LO+1:SKEW_LO], hs_raw, hs_delay);

  // registered horizontal retrace output
  always_ff @(posedge clk)
  begin
    if (rst)
      hretrace <= 1'b0;
    else
      hretrace <= next_hretrace;
  end

  // a vertical total below the current line only takes effect after
  // the counter rolls over the top of its nine-bit range
  // scan line counter wraps after the vertical total
  always_ff @(posedge clk)
  begin
    if (rst)
      line_count <= '0;
    else if (line_step)
      line_count <= (line_count == vert_total) ? 9'h000 : line_count + 9'h001;
  end

  // the end compare only runs while retrace is up, so a stale match of
  // the four low bits cannot end a retrace that has not begun
  // vertical retrace window; end compares four low bits
  always_ff @(posedge clk)
  begin
    if (rst)
      vretrace <= 1'b0;
    else if (line_step && line_count == vs_start)
      vretrace <= 1'b1;
    else if (vretrace && line_count[3:0] == vsync_end_irq_ctrl[3:0])
      vretrace <= 1'b0;
  end

  // active display is high from line zero up to the line before the end line
  always_ff @(posedge clk)
  begin
    if (rst)
      vactive <= 1'b0;
    else
      vactive <= line_count < vact_end;
  end

  // row scan: preset after retrace, step per line, clear at height
  always_ff @(posedge clk)
  begin
    if (rst)
      row_scan <= '0;
    else if (vretrace && line_count[3:0] == vsync_end_irq_ctrl[3:0])
      row_scan <= row_scan_preset[4:0];
    else if (line_step)
      row_scan <= (row_scan == row_height[4:0]) ? 5'h00 : row_scan + 5'h01;
  end

  // the copy lags the registers by one clock, well before any reload
  // frame base and its reload strobe at the end of vertical retrace
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      frame_base <= '0;
      frame_start <= 1'b0;
    end
    else
    begin
      frame_base <= {frame_base_high, frame_base_low};
      frame_start <= vretrace && line_count[3:0] == vsync_end_irq_ctrl[3:0];
    end
  end

  // the even or odd choice is only handed on; the address block acts on it
  // odd or even address after each horizontal retrace
  always_ff @(posedge clk)
  begin
    if (rst)
      odd_start <= 1'b0;
    else
      odd_start <= hsync_end_ctrl[ODD_START_BIT];
  end

  // a top at or above the bottom gives an empty window and so no cursor
  // cursor cell match; row window is top plus one to bottom
  assign cur_raw = mem_addr_count == {cursor_pos_high, cursor_pos_low}
                   && {1'b0, row_scan} >= cursor_top[4:0] + 6'h01
                   && row_scan <= cursor_bottom_skew[4:0];

  // cursor delay line; codes zero and one both give one character
  always_ff @(posedge clk)
  begin
    if (rst)
      cur_delay <= '0;
    else
      cur_delay <= {cur_delay[SKEW_DEPTH-2:0], cur_raw};
  end

  always_comb
  begin
    if (cursor_bottom_skew[SKEW_LO+1:SKEW_LO] == 2'h0)
      next_cursor = cur_delay[0];
    else
      next_cursor = tap(cursor_bottom_skew[SKEW_LO+1:SKEW_LO], cur_raw, cur_delay);
  end

  // registered cursor output
  always_ff @(posedge clk)
  begin
    if (rst)
      cursor_out <= 1'b0;
    else
      cursor_out <= next_cursor;
  end

  // clearing acts on the write itself, not on the stored bit, so a zero
  // left in bit four does not hold the interrupt off for later frames
  // pending interrupt; a set in the clearing cycle wins
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_pending <= 1'b0;
    else if (line_step && line_count == vs_start
             && !vsync_end_irq_ctrl[IRQ_ENABLE_N_BIT])
      irq_pending <= 1'b1;
    else if (data_wr && index == IDX_VS_END && !data_in[IRQ_CLEAR_N_BIT])
      irq_pending <= 1'b0;
  end

  // interrupt pin is driven only while pending, floats otherwise
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      vertical_irq_out <= 1'b0;
      vertical_irq_oe <= 1'b0;
    end
    else
    begin
      vertical_irq_out <= irq_pending;
      vertical_irq_oe <= irq_pending;
    end
  end
endmodule

// ### tb/ctc_partner.sv
// far side model: horizontal character counter and display address bus
module ctc_partner
#(
  parameter int H_TOTAL = 40
)
(
  input wire logic clk,
  input wire logic rst,
  output logic [7:0] hchar_count,
  output logic [15:0] mem_addr_count
);
  timeunit 1ns;
  timeprecision 100ps;
  // one character per clock, wrapping at the line length
  always_ff @(posedge clk)
  begin
    if (rst || hchar_count == 8'(H_TOTAL - 1))
      hchar_count <= 8'h00;
    else
      hchar_count <= hchar_count + 8'h01;
  end
  // address tied to the cell so one cursor cell recurs on every line
  assign mem_addr_count = {hchar_count ^ 8'h5A, hchar_count};
endmodule

// ### tb/ctc_timing_asserts.sv
// concurrent checks on the crt timing block ports
module ctc_timing_asserts
(
  input wire logic clk,
  input wire logic rst,
  input wire logic index_data_select_line,
  input wire logic wr_strobe,
  input wire logic [7:0] data_in,
  input wire logic [7:0] hchar_count,
  input wire logic hretrace,
  input wire logic vretrace,
  input wire logic vactive,
  input wire logic cursor_out,
  input wire logic [4:0] row_scan,
  input wire logic [8:0] line_count,
  input wire logic [15:0] frame_base,
  input wire logic frame_start,
  input wire logic vertical_irq_out,
  input wire logic vertical_irq_oe
);
  import ctc_pkg::*;
  logic [4:0] idx;
  logic [7:0] r [0:31];
  logic [15:0] base;
  logic [8:0] vact;
  logic clr;
  assign base = {r[12], r[13]};
  assign vact = {r[7][NINTH_VACT_BIT], r[18]};
  assign clr = wr_strobe && index_data_select_line && idx == IDX_VS_END
    && !data_in[IRQ_CLEAR_N_BIT];
  // shadow of host writes, so checks follow reprogramming
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      idx <= 5'h00;
      r <= '{default: 8'h00};
    end
    else if (wr_strobe && !index_data_select_line)
      idx <= data_in[4:0];
    else if (wr_strobe)
      r[idx] <= data_in;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_HR_START:
    assert property ($rose(hretrace) && r[5][6:5] == 2'h0
      |-> $past(hchar_count, 2) == $past(r[4], 2)) else $error("hretrace rose off start");
  AST_HR_END:
    assert property ($fell(hretrace) && r[5][6:5] == 2'h0
      |-> $past(hchar_count[4:0], 2) == $past(r[5][4:0], 2)) else $error("hretrace fell off end");
  AST_VR_START:
    assert property ($rose(vretrace) |-> $past(line_count) == {r[7][NINTH_VS_BIT], r[16]})
    else $error("vretrace rose off start line");
  AST_VR_END:
    assert property (vretrace && $past(vretrace) && line_count[3:0] == r[17][3:0]
      |-> ##[0:2] !vretrace) else $error("vretrace outlived end line");
  AST_PRESET:
    assert property ($fell(vretrace) |-> row_scan == r[8][4:0] && frame_start)
    else $error("no preset or frame start after retrace");
  AST_ROW_STEP:
    assert property ($changed(row_scan) |-> row_scan == $past(row_scan) + 5'h01
      || row_scan == 5'h00 || row_scan == r[8][4:0]) else $error("row scan jumped");
  AST_BASE:
    assert property (frame_base == $past(base)) else $error("frame base off registers");
  AST_VACTIVE:
    assert property (vactive == ($past(line_count) < $past(vact))) else $error("vactive wrong");
  AST_IRQ_PIN:
    assert property (vertical_irq_oe == vertical_irq_out) else $error("irq pin not floating");
  AST_IRQ_CLEAR:
    assert property (clr ##1 !$rose(vretrace) |=> !vertical_irq_out) else $error("irq not cleared");
  AST_IRQ_SET:
    assert property ($rose(vretrace) && !r[17][IRQ_ENABLE_N_BIT] |=> vertical_irq_out)
    else $error("irq not raised");
  COV_FRAME: cover property (frame_start);
  COV_IRQ: cover property ($rose(vertical_irq_out));
  COV_CURSOR: cover property ($rose(cursor_out));
endmodule
bind ctc_timing ctc_timing_asserts i_chk (.clk, .rst, .index_data_select_line, .wr_strobe,
  .data_in, .hchar_count, .hretrace, .vretrace, .vactive, .cursor_out, .row_scan,
  .line_count, .frame_base, .frame_start, .vertical_irq_out, .vertical_irq_oe);

// ### tb/ctc_timing_bench.sv
// self-checking bench for the crt timing and cursor registers
module ctc_timing_bench;
  import ctc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, index_data_select_line, wr_strobe, rd_strobe, light_pen_strobe;
  logic [7:0] data_in, data_out, hchar_count, d;
  logic [15:0] mem_addr_count, frame_base, m;
  logic hretrace, vretrace, vactive, cursor_out, frame_start, odd_start;
  logic vertical_irq_out, vertical_irq_oe;
  logic [4:0] row_scan;
  logic [8:0] line_count;
  logic [7:0] v [0:3];
  int fails, comparisons, seed, cycles, k;
  ctc_partner i_far (.clk, .rst, .hchar_count, .mem_addr_count);
  ctc_timing i_dut (.clk, .rst, .index_data_select_line, .wr_strobe, .rd_strobe, .data_in,
    .data_out, .hchar_count, .mem_addr_count, .light_pen_strobe, .hretrace, .vretrace,
    .vactive, .cursor_out, .row_scan, .line_count, .frame_base, .frame_start, .odd_start,
    .vertical_irq_out, .vertical_irq_oe);
  // expected count seen when the delayed outputs first show
  function automatic logic [7:0] hr_at(input logic [1:0] s);
    return 8'h20 + 8'(s);
  endfunction
  function automatic logic [7:0] cur_at(input logic [1:0] s);
    return 8'h06 + (s == 2'h0 ? 8'h01 : 8'(s));
  endfunction
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // index write; the strobe stays up for whatever follows
  task automatic pick(input logic [4:0] a);
    @(posedge clk);
    index_data_select_line <= 1'b0;
    data_in <= {3'h0, a};
    wr_strobe <= 1'b1;
    @(posedge clk);
  endtask
  task automatic put(input logic [4:0] a, input logic [7:0] x);
    pick(a);
    index_data_select_line <= 1'b1;
    data_in <= x;
    @(posedge clk);
    wr_strobe <= 1'b0;
  endtask
  task automatic get(input logic [4:0] a, output logic [7:0] x);
    pick(a);
    wr_strobe <= 1'b0;
    index_data_select_line <= 1'b1;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    @(posedge clk);
    x = data_out;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard, well above the planned run
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 40000)
    begin
      fails++;
      conclude();
    end
  end
  initial
  begin
    seed = 6;
    rst = 1'b1;
    {index_data_select_line, wr_strobe, rd_strobe, light_pen_strobe} = 4'h0;
    data_in = 8'h00;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      v[i] = 8'($random(seed));
      put(IDX_BASE_HI + 5'(i), v[i]);
      get(IDX_BASE_HI + 5'(i), d);
      chk("rw byte", 16'(d), 16'(v[i]));
    end
    chk("frame base", frame_base, {v[0], v[1]});
    // 40 chars a line, 20 lines a frame; test bit kept low
    put(IDX_HS_START, 8'h1E);
    put(IDX_HS_END, 8'h82);
    put(IDX_VT_LOW, 8'h13);
    put(IDX_ROW_PRESET, 8'h01);
    put(IDX_ROW_HEIGHT, 8'h03);
    put(IDX_CPOS_HI, 8'h5F);
    put(IDX_CPOS_LO, 8'h05);
    put(IDX_VS_START, 8'h0F);
    put(IDX_VS_END, 8'h11);
    put(IDX_VACT_END, 8'h0C);
    chk("odd start", 16'(odd_start), 16'h0001);
    get(IDX_HS_START, d);
    chk("write-only read", 16'(d), 16'h0000);
    light_pen_strobe <= 1'b1;
    @(posedge clk);
    m = mem_addr_count;
    get(IDX_VS_START, d);
    chk("pen high", 16'(d), 16'(m[15:8]));
    get(IDX_VS_END, d);
    chk("pen low", 16'(d), 16'(m[7:0]));
    light_pen_strobe <= 1'b0;
    for (k = 0; k < 2000 && frame_start !== 1'b1; k++) @(posedge clk);
    chk("row preset", 16'(row_scan), 16'h0001);
    for (int j = 2; j < 6; j++)
    begin
      m = 16'(line_count);
      for (k = 0; k < 100 && 16'(line_count) == m; k++) @(posedge clk);
      chk("row step", 16'(row_scan), 16'(j % 4));
    end
    for (k = 0; k < 2000 && vertical_irq_out !== 1'b1; k++) @(posedge clk);
    repeat (50) @(posedge clk);
    chk("irq held", 16'({vertical_irq_out, vertical_irq_oe}), 16'h0003);
    put(IDX_VS_END, 8'h21);
    repeat (900) @(posedge clk);
    chk("irq cleared, off", 16'({vertical_irq_out, vertical_irq_oe}), 16'h0000);
    put(IDX_NINTH, 8'h03);
    for (k = 0; k < 12000 && line_count !== 9'h0F0; k++) @(posedge clk);
    chk("active late", 16'(vactive), 16'h0001);
    for (k = 0; k < 2000 && line_count !== 9'h110; k++) @(posedge clk);
    chk("nine-bit total", 16'(line_count), 16'h0110);
    // vactive trails the line counter by one clock
    @(posedge clk);
    chk("active ended", 16'(vactive), 16'h0000);
    for (int s = 0; s < 4; s++)
    begin
      put(IDX_HS_END, {1'b0, 2'(s), 5'h02});
      put(IDX_CUR_BOT, {1'b0, 2'(s), 5'h1F});
      repeat (8) @(posedge clk);
      for (k = 0; k < 200 && hretrace !== 1'b0; k++) @(posedge clk);
      for (k = 0; k < 200 && hretrace !== 1'b1; k++) @(posedge clk);
      chk("retrace delay", 16'(hchar_count), 16'(hr_at(2'(s))));
      for (k = 0; k < 200 && cursor_out !== 1'b0; k++) @(posedge clk);
      for (k = 0; k < 200 && cursor_out !== 1'b1; k++) @(posedge clk);
      chk("cursor delay", 16'(hchar_count), 16'(cur_at(2'(s))));
    end
    put(IDX_CUR_TOP, 8'h02);
    put(IDX_CUR_BOT, 8'h02);
    // let a cursor launched under the old window drain out of the skew line
    repeat (8) @(posedge clk);
    d = 8'h00;
    for (k = 0; k < 400; k++) @(posedge clk) d[0] = d[0] | cursor_out;
    chk("empty cursor", 16'(d), 16'h0000);
    conclude();
  end
endmodule
